// ---- dram_pre_ref_pkg.sv ----
// package: command codes, timing counts and bank state carrier for precharge/refresh logic
package dram_pre_ref_pkg;
    localparam int NUM_BANKS = 8;
    localparam int BA_W = 3;
    localparam int AP_BIT = 10;
    localparam int CNT_W = 12;
    // timing counts in clock cycles (fixed package constants, not per-instance parameters)
    localparam logic [CNT_W-1:0] T_RTP_CYC = 12'h0004;
    localparam logic [CNT_W-1:0] T_RAS_CYC = 12'h0010;
    localparam logic [CNT_W-1:0] T_WR_CYC = 12'h0008;
    localparam logic [CNT_W-1:0] T_RP_CYC = 12'h0006;
    localparam logic [CNT_W-1:0] T_RFC_CYC = 12'h0040;
    localparam logic [CNT_W-1:0] T_CKESR_CYC = 12'h0006;
    localparam logic [CNT_W-1:0] T_SREF_INT_CYC = 12'h0004;
    localparam logic [CNT_W-1:0] BURST_CYC = 12'h0004;
    localparam logic [3:0] MAX_OWED = 4'h8;
    // command pin pattern {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // command bus bundle sampled at the rising edge
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic odt;
        logic [BA_W-1:0] ba;
        logic [15:0] addr;
    } cmd_bus_t;

    // per-bank pending auto precharge
    typedef struct packed {
        logic pend;
        logic [CNT_W-1:0] wait_cnt;
    } ap_slot_t;
endpackage

// ---- dram_precharge_refresh_logic.sv ----
// device-side bank closing, auto precharge, refresh and self-refresh tracking
`timescale 1ns/1ps

// Functional notes
// [RULE1] precharge closes coded bank or all
// [RULE2] read/write A10 selects auto precharge
// [RULE3] read AP starts AL+tRTP, waits tRAS
// [RULE4] controller waits tRP and tRC to activate
// [RULE5] write AP waits burst plus tWR
// [RULE6] controller waits tWR+tRP and tRC
// [RULE7] auto precharge held until restore done
// [RULE8] refresh decode: cs ras cas low, we high
// [RULE9] controller refreshes idle banks every tREFI
// [RULE10] refresh uses internal row counter, banks idle
// [RULE11] controller sends only nop during tRFC
// [RULE12] controller postpones or pulls in at most 8
// [RULE13] controller limits 16 refreshes per 2 tREFI
// [RULE14] owed count frozen in self-refresh, max eight
// [RULE15] self-refresh entry decode with cke low
// [RULE16] controller idles banks, termination off first
// [RULE17] loop off in self-refresh, reset on exit
// [RULE18] ignore controls in self-refresh, refresh within tCKESR
// [RULE19] controller sends nop after entry, clock rules
// [RULE20] exit with cke high and nop
// [RULE21] controller delays writes 512 cycles after exit
// [RULE22] controller refreshes once before re-entry
// [RULE23] precharge decode: cs ras we low, cas high
module dram_precharge_refresh_logic #(
    parameter int AL_CYC = 0, // additive latency in cycles
    parameter int ROW_W = 14, // internal refresh row counter width
    parameter int OWED_W = 5 // signed owed refresh counter width
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire dram_pre_ref_pkg::cmd_bus_t cmd_in, // sampled command bus
    input wire logic refi_tick_in, // one pulse per average refresh interval
    input wire logic dll_on_in, // mode_register_one bit A0 low means loop on
    output logic [7:0] bank_open_out, // one bit per open bank
    output logic [7:0] bank_precharging_out, // bank in precharge
    output logic refresh_busy_out, // internal refresh in progress
    output logic self_refresh_out, // in self-refresh
    output logic dll_enable_out, // delay-locked loop enabled
    output logic dll_reset_out, // one-cycle loop reset on exit
    output logic [ROW_W-1:0] refresh_row_out, // internal refresh row address
    output logic signed [OWED_W-1:0] owed_out // postponed (+) or pulled-in (-)
);
    localparam logic [11:0] AL_C = 12'(AL_CYC);

    // command decode
    logic [3:0] pat;
    logic is_pre, is_ref, is_act, is_rd, is_wr, is_sre, is_srx;
    logic ap_bit;
    logic [7:0] ba_dec;

    // bank state
    logic [7:0] open_r, open_nxt;
    logic [7:0] prech_r, prech_nxt;
    logic [11:0] ras_cnt_r [8];
    logic [11:0] ras_cnt_nxt [8];
    logic [11:0] rp_cnt_r [8];
    logic [11:0] rp_cnt_nxt [8];
    dram_pre_ref_pkg::ap_slot_t ap_r [8];
    dram_pre_ref_pkg::ap_slot_t ap_nxt [8];

    // refresh / self-refresh state
    typedef enum logic [1:0] {ST_NORMAL, ST_REFRESH, ST_SELF} mode_t;
    mode_t mode_r, mode_nxt;
    logic [11:0] rfc_cnt_r, rfc_cnt_nxt;
    logic [11:0] sr_cnt_r, sr_cnt_nxt;
    logic [ROW_W-1:0] row_r, row_nxt;
    logic signed [OWED_W-1:0] owed_r, owed_nxt;
    logic dll_en_r, dll_en_nxt;
    logic dll_rst_r, dll_rst_nxt;
    logic sr_done_r, sr_done_nxt;

    // decode is blind while in self-refresh, except the exit pattern
    always_comb begin
        pat = {cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
        ap_bit = cmd_in.addr[dram_pre_ref_pkg::AP_BIT];
        ba_dec = 8'h01 << cmd_in.ba;
        // [RULE23] precharge pattern
        is_pre = (mode_r == ST_NORMAL) && cmd_in.cke && (pat == dram_pre_ref_pkg::CMD_PRECHARGE);
        // [RULE8] refresh pattern with cke high
        is_ref = (mode_r == ST_NORMAL) && cmd_in.cke && (pat == dram_pre_ref_pkg::CMD_REFRESH);
        // [RULE15] same pattern with cke low enters self-refresh
        is_sre = (mode_r == ST_NORMAL) && !cmd_in.cke && (pat == dram_pre_ref_pkg::CMD_REFRESH);
        // activate, read and write only count outside refresh and self-refresh
        is_act = (mode_r == ST_NORMAL) && cmd_in.cke && (pat == dram_pre_ref_pkg::CMD_ACTIVATE);
        is_rd = (mode_r == ST_NORMAL) && cmd_in.cke && (pat == dram_pre_ref_pkg::CMD_READ);
        is_wr = (mode_r == ST_NORMAL) && cmd_in.cke && (pat == dram_pre_ref_pkg::CMD_WRITE);
        // [RULE20] exit: cke high with nop or deselect_cmd
        is_srx = (mode_r == ST_SELF) && cmd_in.cke && sr_done_r &&
            (cmd_in.cs_n || (pat == dram_pre_ref_pkg::CMD_NOP));
    end

    // bank next-state: activation, precharge and auto precharge timers
    always_comb begin
        open_nxt = open_r;
        prech_nxt = prech_r;
        for (int b = 0; b < 8; b++) begin
            ras_cnt_nxt[b] = (ras_cnt_r[b] != 12'h0000) ? ras_cnt_r[b] - 12'h0001 : 12'h0000;
            rp_cnt_nxt[b] = (rp_cnt_r[b] != 12'h0000) ? rp_cnt_r[b] - 12'h0001 : 12'h0000;
            ap_nxt[b] = ap_r[b];
            if (prech_r[b] && rp_cnt_r[b] <= 12'h0001) begin
                prech_nxt[b] = 1'b0;
            end
            if (ap_r[b].pend) begin
                if (ap_r[b].wait_cnt != 12'h0000) begin
                    ap_nxt[b].wait_cnt = ap_r[b].wait_cnt - 12'h0001;
                // [RULE3] defer start until row active time met
                // [RULE7] restore lockout holds the precharge
                end else if (ras_cnt_r[b] == 12'h0000) begin
                    ap_nxt[b].pend = 1'b0;
                    open_nxt[b] = 1'b0;
                    prech_nxt[b] = 1'b1;
                    rp_cnt_nxt[b] = dram_pre_ref_pkg::T_RP_CYC;
                end
            end
        end
        if (is_act) begin
            open_nxt = open_r | ba_dec;
            // loaded one short so that an auto close lands on the tRAS edge itself
            ras_cnt_nxt[cmd_in.ba] = dram_pre_ref_pkg::T_RAS_CYC - 12'h0001;
        end
        // [RULE1] single bank by BA, or all when A10 high
        if (is_pre) begin
            for (int b = 0; b < 8; b++) begin
                if ((ap_bit || ba_dec[b]) && open_r[b]) begin
                    open_nxt[b] = 1'b0;
                    prech_nxt[b] = 1'b1;
                    rp_cnt_nxt[b] = dram_pre_ref_pkg::T_RP_CYC;
                    // an explicit precharge wins over a pending auto precharge
                    ap_nxt[b].pend = 1'b0;
                end
            end
        end
        // [RULE2] A10 high arms auto precharge, low leaves bank open
        if ((is_rd || is_wr) && ap_bit) begin
            ap_nxt[cmd_in.ba].pend = 1'b1;
            // [RULE3] read waits AL plus tRTP
            // [RULE5] write waits AL, burst, then recovery
            ap_nxt[cmd_in.ba].wait_cnt = is_rd ? (AL_C + dram_pre_ref_pkg::T_RTP_CYC - 12'h0001)
                : (AL_C + dram_pre_ref_pkg::BURST_CYC + dram_pre_ref_pkg::T_WR_CYC - 12'h0001);
        end
    end

    // mode machine: refresh cycle and self-refresh
    always_comb begin
        mode_nxt = mode_r;
        rfc_cnt_nxt = (rfc_cnt_r != 12'h0000) ? rfc_cnt_r - 12'h0001 : 12'h0000;
        sr_cnt_nxt = sr_cnt_r;
        row_nxt = row_r;
        owed_nxt = owed_r;
        dll_en_nxt = dll_en_r;
        dll_rst_nxt = 1'b0;
        sr_done_nxt = sr_done_r;
        // [RULE14] count frozen only in self-refresh
        // ticks keep counting during tRFC; compares are signed for pulled-in refreshes
        if (mode_r != ST_SELF) begin
            if (refi_tick_in && !is_ref &&
                owed_r < $signed(OWED_W'(dram_pre_ref_pkg::MAX_OWED))) begin
                owed_nxt = owed_r + OWED_W'(1);
            end else if (is_ref && !refi_tick_in &&
                owed_r > -$signed(OWED_W'(dram_pre_ref_pkg::MAX_OWED))) begin
                owed_nxt = owed_r - OWED_W'(1);
            end
        end
        unique case (mode_r)
            ST_NORMAL: begin
                if (is_ref) begin
                    // [RULE10] internal row counter, address ignored
                    mode_nxt = ST_REFRESH;
                    rfc_cnt_nxt = dram_pre_ref_pkg::T_RFC_CYC;
                    row_nxt = row_r + ROW_W'(1);
                end else if (is_sre) begin
                    mode_nxt = ST_SELF;
                    sr_cnt_nxt = 12'h0000;
                    sr_done_nxt = 1'b0;
                    // [RULE17] loop off on entry when enabled
                    if (dll_on_in) begin
                        dll_en_nxt = 1'b0;
                    end
                end
            end
            ST_REFRESH: begin
                if (rfc_cnt_r <= 12'h0001) begin
                    mode_nxt = ST_NORMAL;
                end
            end
            ST_SELF: begin
                // [RULE14] owed count frozen here
                // [RULE18] internal refresh within tCKESR, controls ignored
                // one internal refresh, early enough to land inside tCKESR
                sr_cnt_nxt = sr_cnt_r + 12'h0001;
                if (sr_cnt_r == dram_pre_ref_pkg::T_SREF_INT_CYC - 12'h0001) begin
                    row_nxt = row_r + ROW_W'(1);
                end
                if (sr_cnt_r >= dram_pre_ref_pkg::T_CKESR_CYC - 12'h0001) begin
                    sr_done_nxt = 1'b1;
                end
                if (is_srx) begin
                    mode_nxt = ST_NORMAL;
                    // [RULE17] loop back on with a reset
                    if (dll_on_in) begin
                        dll_en_nxt = 1'b1;
                        dll_rst_nxt = 1'b1;
                    end
                end
            end
        endcase
    end

    // registers
    // synchronous reset: banks closed, loop on, counts cleared
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            open_r <= 8'h00;
            prech_r <= 8'h00;
            for (int b = 0; b < 8; b++) begin
                ras_cnt_r[b] <= 12'h0000;
                rp_cnt_r[b] <= 12'h0000;
                ap_r[b] <= '0;
            end
            mode_r <= ST_NORMAL;
            rfc_cnt_r <= 12'h0000;
            sr_cnt_r <= 12'h0000;
            row_r <= '0;
            owed_r <= '0;
            dll_en_r <= 1'b1;
            dll_rst_r <= 1'b0;
            sr_done_r <= 1'b0;
        end else begin
            open_r <= open_nxt;
            prech_r <= prech_nxt;
            ras_cnt_r <= ras_cnt_nxt;
            rp_cnt_r <= rp_cnt_nxt;
            ap_r <= ap_nxt;
            mode_r <= mode_nxt;
            rfc_cnt_r <= rfc_cnt_nxt;
            sr_cnt_r <= sr_cnt_nxt;
            row_r <= row_nxt;
            owed_r <= owed_nxt;
            dll_en_r <= dll_en_nxt;
            dll_rst_r <= dll_rst_nxt;
            sr_done_r <= sr_done_nxt;
        end
    end

    // outputs straight from flops
    assign bank_open_out = open_r;
    assign bank_precharging_out = prech_r;
    assign refresh_busy_out = (mode_r == ST_REFRESH);
    assign self_refresh_out = (mode_r == ST_SELF);
    assign dll_enable_out = dll_en_r;
    assign dll_reset_out = dll_rst_r;
    assign refresh_row_out = row_r;
    assign owed_out = owed_r;

    // checks
    a_pre_all: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE1]
        is_pre && ap_bit |=> open_r == 8'h00)
        else $error("precharge all left a bank open");
    a_pre_one: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE1]
        is_pre && !ap_bit && !is_act |=> (open_r & ~$past(open_r)) == 8'h00 &&
        !open_r[$past(cmd_in.ba)])
        else $error("single precharge left coded bank open");
    a_ap_arm: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE2]
        (is_rd || is_wr) && ap_bit |=> ap_r[$past(cmd_in.ba)].pend)
        else $error("auto precharge not armed");
    a_ap_ras: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE7]
        ap_r[0].pend && ap_r[0].wait_cnt == 12'h0000 && ras_cnt_r[0] != 12'h0000 |=> open_r[0] ||
        !$past(open_r[0]) || $past(is_pre))
        else $error("auto precharge before restore");
    a_ref_mode: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE8]
        is_ref |=> refresh_busy_out && refresh_row_out == $past(row_r) + ROW_W'(1))
        else $error("refresh not started");
    a_sre_mode: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE15]
        is_sre |=> self_refresh_out)
        else $error("self-refresh not entered");
    a_owed_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE14]
        self_refresh_out && $past(self_refresh_out) |-> $stable(owed_r))
        else $error("owed count moved in self-refresh");
    a_dll_off: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
        is_sre && dll_on_in |=> !dll_enable_out)
        else $error("loop not off in self-refresh");
    a_sr_min: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE18]
        is_sre |=> self_refresh_out [*6])
        else $error("self-refresh left early");
    // the owed count never leaves the window of eight either way
    a_owed_bound: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE14]
        owed_r <= $signed(OWED_W'(dram_pre_ref_pkg::MAX_OWED)) &&
        owed_r >= -$signed(OWED_W'(dram_pre_ref_pkg::MAX_OWED)))
        else $error("owed count out of range");
    a_dll_back: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
        is_srx && dll_on_in |=> dll_enable_out && dll_reset_out)
        else $error("loop not restarted on exit");
    // only the exit pattern may take the device out of self-refresh
    a_sr_stay: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE18]
        self_refresh_out && !is_srx |=> self_refresh_out)
        else $error("self-refresh left without exit");
    // main scenarios reached
    c_ap_read: cover property (@(posedge clk_in) is_rd && ap_bit ##[1:40] prech_r != 8'h00);
    c_ap_write: cover property (@(posedge clk_in) is_wr && ap_bit ##[1:40] prech_r != 8'h00);
    c_refresh: cover property (@(posedge clk_in) is_ref ##1 refresh_busy_out);
    c_sr_cycle: cover property (@(posedge clk_in) is_sre ##[6:60] is_srx);
    c_sr_no_dll: cover property (@(posedge clk_in) is_sre && !dll_on_in);
endmodule

// ---- dram_ctrl_model.sv ----
// controller-side partner: forwards bench commands and keeps the bus duties
`timescale 1ns/1ps
module dram_ctrl_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire dram_pre_ref_pkg::cmd_bus_t req_in, // command asked for by the bench
    output dram_pre_ref_pkg::cmd_bus_t cmd_out // command placed on the bus
);
    logic [3:0] code; // pin pattern after filtering
    logic [11:0] hold_r; // nop cycles still owed after a refresh
    logic [11:0] hold_nxt;
    logic [15:0] addr_r; // last address driven
    logic [15:0] addr_nxt;
    // bus value: the request, filtered by the duties below
    always_comb begin
        code = {req_in.cs_n, req_in.ras_n, req_in.cas_n, req_in.we_n};
        // only nop inside the refresh cycle
        if (hold_r != 12'h000) begin
            code = dram_pre_ref_pkg::CMD_NOP;
        end
        cmd_out = req_in;
        {cmd_out.cs_n, cmd_out.ras_n, cmd_out.cas_n, cmd_out.we_n} = code;
        // termination always off; open banks are not checked before self-refresh entry
        cmd_out.odt = 1'b0;
        // idle address lines flip so a stale value never looks valid
        if (code == dram_pre_ref_pkg::CMD_NOP) begin
            cmd_out.addr = ~addr_r;
        end
    end
    // next state of the spacing counter and the address memory
    always_comb begin
        hold_nxt = (hold_r != 12'h000) ? hold_r - 12'h001 : 12'h000;
        // a refresh with cke high opens the nop span
        if (code == dram_pre_ref_pkg::CMD_REFRESH && cmd_out.cke) begin
            hold_nxt = dram_pre_ref_pkg::T_RFC_CYC;
        end
        addr_nxt = cmd_out.addr;
    end
    // registers only
    always_ff @(posedge clk_in) begin
        hold_r <= rst_in ? 12'h000 : hold_nxt;
        addr_r <= rst_in ? 16'h0000 : addr_nxt;
    end
endmodule

// ---- dram_precharge_refresh_logic_test.sv ----
// self-checking bench for bank closing, refresh and self-refresh
`timescale 1ns/1ps
module dram_precharge_refresh_logic_test;
    localparam logic [3:0] C_ACT = dram_pre_ref_pkg::CMD_ACTIVATE;
    localparam logic [3:0] C_PRE = dram_pre_ref_pkg::CMD_PRECHARGE;
    localparam logic [3:0] C_RD = dram_pre_ref_pkg::CMD_READ;
    localparam logic [3:0] C_WR = dram_pre_ref_pkg::CMD_WRITE;
    localparam logic [3:0] C_REF = dram_pre_ref_pkg::CMD_REFRESH;
    localparam logic [3:0] C_NOP = dram_pre_ref_pkg::CMD_NOP;
    logic clk_in = 1'b0; // 25 MHz clock
    logic rst_in = 1'b1; // reset held at start
    dram_pre_ref_pkg::cmd_bus_t req; // bench request
    dram_pre_ref_pkg::cmd_bus_t cmd; // bus after the partner
    logic tick = 1'b0; // refresh interval pulse
    logic dll_on = 1'b1; // loop on
    logic [7:0] open_b, pre_b;
    logic busy, self_m, dll_en, dll_rst;
    logic [13:0] row;
    logic signed [4:0] owed;
    logic [9:0] mon; // flags that get counted over a span
    int err_total = 0;
    int n_checks = 0;
    int h;
    assign mon = {pre_b, dll_rst, busy};
    always #20 clk_in = ~clk_in;
    dram_ctrl_model partner (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .cmd_out(cmd));
    dram_precharge_refresh_logic uut (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd),
        .refi_tick_in(tick), .dll_on_in(dll_on), .bank_open_out(open_b),
        .bank_precharging_out(pre_b), .refresh_busy_out(busy), .self_refresh_out(self_m),
        .dll_enable_out(dll_en), .dll_reset_out(dll_rst), .refresh_row_out(row),
        .owed_out(owed));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // one command, then nop with the same cke level
    task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic a10,
        input logic cke);
        @(posedge clk_in);
        {req.cs_n, req.ras_n, req.cas_n, req.we_n} <= c;
        req.ba <= ba;
        req.addr <= {5'h00, a10, 10'h000};
        req.cke <= cke;
        @(posedge clk_in);
        {req.cs_n, req.ras_n, req.cas_n, req.we_n} <= C_NOP;
        #1;
    endtask
    // counts the cycles in which one monitored flag is high
    task automatic span(input int bitn, input int n);
        h = 0;
        repeat (n) begin
            if (mon[bitn] === 1'b1) h++;
            cyc(1);
        end
    endtask
    task automatic pulse_tick;
        @(posedge clk_in);
        tick <= 1'b1;
        @(posedge clk_in);
        tick <= 1'b0;
        #1;
    endtask
    task automatic t_reset;
        chk("open", 16'h0000, 16'(open_b));
        chk("dll", 16'h0001, 16'(dll_en));
        chk("row", 16'h0000, 16'(row));
        chk("owed", 16'h0000, 16'($unsigned(owed)));
    endtask
    // every bank code closed alone, then all at once
    task automatic t_precharge;
        for (int k = 0; k < 8; k++) issue(C_ACT, 3'(k), 1'b0, 1'b1);
        for (int b = 0; b < 8; b++) begin
            issue(C_PRE, 3'(b), 1'b0, 1'b1);
            span(2 + b, 10);
            chk("pre time", 16'h0006, 16'(h));
            chk("pre one", 16'(8'hff & ~(8'h01 << b)), 16'(open_b));
            issue(C_ACT, 3'(b), 1'b0, 1'b1);
        end
        issue(C_PRE, 3'h5, 1'b1, 1'b1);
        cyc(2);
        chk("pre all bank", 16'h00ff, 16'(pre_b));
        chk("pre all open", 16'h0000, 16'(open_b));
        cyc(8);
    endtask
    task automatic t_read_ap;
        issue(C_ACT, 3'h2, 1'b0, 1'b1);
        issue(C_RD, 3'h2, 1'b0, 1'b1);
        cyc(30);
        chk("rd open", 16'h0004, 16'(open_b));
        issue(C_RD, 3'h2, 1'b1, 1'b1);
        cyc(3);
        chk("rda early", 16'h0004, 16'(open_b));
        cyc(2);
        chk("rda closed", 16'h0000, 16'(open_b));
        // wait beyond tRP before the next activation
        cyc(8);
        issue(C_ACT, 3'h0, 1'b0, 1'b1);
        issue(C_RD, 3'h0, 1'b1, 1'b1);
        cyc(13);
        chk("ras hold", 16'h0001, 16'(open_b));
        cyc(1);
        chk("ras closed", 16'h0000, 16'(open_b));
        cyc(8);
    endtask
    task automatic t_write_ap;
        issue(C_ACT, 3'h4, 1'b0, 1'b1);
        cyc(20);
        issue(C_WR, 3'h4, 1'b1, 1'b1);
        cyc(11);
        chk("wra early", 16'h0010, 16'(open_b));
        cyc(1);
        chk("wra closed", 16'h0000, 16'(open_b));
        // recovery plus tRP before any further activation
        cyc(8);
    endtask
    task automatic t_refresh;
        // one refresh here, far below sixteen
        repeat (3) pulse_tick;
        cyc(1);
        chk("owed up", 16'h0003, 16'($unsigned(owed)));
        // banks idle well past tRP; the address lines carry junk
        issue(C_REF, 3'h7, 1'b1, 1'b1);
        span(0, 80);
        chk("rfc", 16'h0040, 16'(h));
        chk("ref row", 16'h0001, 16'(row));
        chk("ref idle", 16'h0000, 16'(open_b));
        chk("owed down", 16'h0002, 16'($unsigned(owed)));
    endtask
    task automatic t_self_refresh;
        issue(C_REF, 3'h0, 1'b0, 1'b0);
        cyc(1);
        chk("sref in", 16'h0001, 16'(self_m));
        chk("dll off", 16'h0000, 16'(dll_en));
        issue(C_ACT, 3'h1, 1'b0, 1'b0);
        cyc(1);
        chk("sref ignore", 16'h0000, 16'(open_b));
        repeat (2) pulse_tick;
        chk("sref row", 16'h0002, 16'(row));
        // exit is cke high with a nop
        issue(C_NOP, 3'h0, 1'b0, 1'b1);
        span(1, 4);
        chk("dll reset", 16'h0001, 16'(h));
        chk("sref out", 16'h0000, 16'(self_m));
        chk("dll on", 16'h0001, 16'(dll_en));
        chk("owed kept", 16'h0002, 16'($unsigned(owed)));
    endtask
    // a second stay with the loop off: no loop toggling, no loop reset
    task automatic t_sref_loop_off;
        // no write or leveling follows the first exit
        cyc(10);
        // one refresh before self-refresh is entered again
        issue(C_REF, 3'h0, 1'b0, 1'b1);
        cyc(70);
        // loop-off mode for the second stay
        @(posedge clk_in);
        dll_on <= 1'b0;
        issue(C_REF, 3'h0, 1'b0, 1'b0);
        cyc(1);
        chk("sref2 in", 16'h0001, 16'(self_m));
        chk("dll kept", 16'h0001, 16'(dll_en));
        cyc(8);
        issue(C_NOP, 3'h0, 1'b0, 1'b1);
        span(1, 4);
        chk("no dll reset", 16'h0000, 16'(h));
        chk("sref2 out", 16'h0000, 16'(self_m));
        chk("owed after ref", 16'h0001, 16'($unsigned(owed)));
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        req = {1'b1, C_NOP, 20'h0_0000};
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        cyc(2);
        t_reset;
        t_precharge;
        t_read_ap;
        t_write_ap;
        t_refresh;
        t_self_refresh;
        t_sref_loop_off;
        wrap_up;
    end
    // watchdog: the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        $display("MISMATCH watchdog expected done seen hang");
        wrap_up;
    end
endmodule
